// ---- asf_alu_status_flags.sv ----
// ALU with status flag logic behind an AXI4-Lite slave
// assumes one 125 MHz clock, a synchronous active-low reset and a
// master that keeps at most one write and one read under way
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "asf_regs.svh"
module asf_alu_status_flags
   import asf_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic extended_set_enable,
   output logic [7:0] alu_condition_flags
);
   // bus handshake state
   logic [31:0] awaddr_reg, awaddr_next;
   logic aw_have_reg, aw_have_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic w_have_reg, w_have_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   // datapath state
   logic [4:0] flags_reg, flags_next;
   logic [7:0] opa_reg, opa_next;
   logic [7:0] opb_reg, opb_next;
   logic [7:0] result_reg, result_next;
   logic [2:0] bitsel_reg, bitsel_next;
   logic dest_flags_reg, dest_flags_next;
   asf_mode_t mode_reg, mode_next;
   logic extended_set_enable_s1_reg, extended_set_enable_s2_reg;

   logic wr_fire;
   logic op_go;
   asf_op_t op_code;
   logic [7:0] src;
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] b_eff;
   logic c_in;
   logic [7:0] alu_out;
   logic [4:0] alu_flags;
   logic [4:0] upd_mask;
   logic [7:0] status_view;

   assign status_view = {3'h0, flags_reg};
   assign alu_condition_flags = status_view;

   assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
   assign s_axi_awready = !aw_have_reg && !bvalid_reg;
   assign s_axi_wready = !w_have_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // op word: [3:0] opcode, [6:4] bit select, [7] result goes to status register
   assign op_go = wr_fire && awaddr_reg == `ASF_OP_ADDR && wstrb_reg[0];
   assign op_code = asf_op_t'(wdata_reg[3:0]);
   // with destination = status, the source operand is the status register itself
   assign src = wdata_reg[7] ? status_view : opa_reg;

   always_comb begin
      c_in = 1'b0;
      b_eff = opb_reg;
      if (op_code == ASF_OP_SUB) begin
         b_eff = ~opb_reg;
         c_in = 1'b1;
      end
      sum = {1'b0, src} + {1'b0, b_eff} + {8'h00, c_in};
      low_sum = {1'b0, src[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_in};
      alu_out = 8'h00;
      alu_flags = flags_reg;
      upd_mask = 5'h00;
      case (op_code)
         ASF_OP_ADD, ASF_OP_SUB: begin
            alu_out = sum[7:0];
            upd_mask = 5'h1F;
            alu_flags[`ASF_BIT_HALF] = low_sum[4];
            alu_flags[`ASF_BIT_CARRY] = sum[8];
            alu_flags[`ASF_BIT_OVF] = (src[7] == b_eff[7]) && (sum[7] != src[7]);
         end
         ASF_OP_AND: begin
            alu_out = src & opb_reg;
            upd_mask = 5'h14;
         end
         ASF_OP_CLR: begin
            alu_out = 8'h00;
            upd_mask = 5'h04;
         end
         ASF_OP_ROTL: begin
            alu_out = {src[6:0], flags_reg[`ASF_BIT_CARRY]};
            upd_mask = 5'h17;
            alu_flags[`ASF_BIT_CARRY] = src[7];
            alu_flags[`ASF_BIT_HALF] = src[3];
         end
         ASF_OP_ROTR: begin
            alu_out = {flags_reg[`ASF_BIT_CARRY], src[7:1]};
            upd_mask = 5'h17;
            alu_flags[`ASF_BIT_CARRY] = src[0];
            alu_flags[`ASF_BIT_HALF] = src[4];
         end
         ASF_OP_MOVE: alu_out = src;
         ASF_OP_BITCLR: alu_out = src & ~(8'h01 << wdata_reg[6:4]);
         ASF_OP_BITSET: alu_out = src | (8'h01 << wdata_reg[6:4]);
         ASF_OP_SWAP: alu_out = {src[3:0], src[7:4]};
         default: alu_out = src;
      endcase
      if (upd_mask[`ASF_BIT_NEG]) alu_flags[`ASF_BIT_NEG] = alu_out[7];
      if (upd_mask[`ASF_BIT_ZERO]) alu_flags[`ASF_BIT_ZERO] = (alu_out == 8'h00);
   end

   always_comb begin
      awaddr_next = awaddr_reg;
      aw_have_next = aw_have_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      w_have_next = w_have_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      flags_next = flags_reg;
      opa_next = opa_reg;
      opb_next = opb_reg;
      result_next = result_reg;
      bitsel_next = bitsel_reg;
      dest_flags_next = dest_flags_reg;
      mode_next = mode_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         awaddr_next = s_axi_awaddr;
         aw_have_next = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
         w_have_next = 1'b1;
      end
      if (wr_fire) begin
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = `ASF_RESP_OKAY;
         case (awaddr_reg)
            `ASF_FLAGS_ADDR: if (wstrb_reg[0]) flags_next = wdata_reg[4:0];
            `ASF_OPA_ADDR: if (wstrb_reg[0]) opa_next = wdata_reg[7:0];
            `ASF_OPB_ADDR: if (wstrb_reg[0]) opb_next = wdata_reg[7:0];
            `ASF_OP_ADDR: begin
               if (op_go) begin
                  bitsel_next = wdata_reg[6:4];
                  dest_flags_next = wdata_reg[7];
                  // a flag-updating op drops the data write; only the flags in its mask change, the others hold
                  if (wdata_reg[7] && upd_mask != 5'h00)
                     flags_next = (alu_flags & upd_mask) | (flags_reg & ~upd_mask);
                  else if (wdata_reg[7])
                     flags_next = alu_out[4:0];
                  else begin
                     flags_next = (alu_flags & upd_mask) | (flags_reg & ~upd_mask);
                     result_next = alu_out;
                  end
               end
            end
            `ASF_CFG_ADDR: begin
               // indexed mode needs the extended set; otherwise falls back to direct
               if (wstrb_reg[0]) begin
                  if (asf_mode_t'(wdata_reg[2:0]) == ASF_AM_INDEXED && !extended_set_enable_s2_reg)
                     mode_next = ASF_AM_DIRECT;
                  else if (wdata_reg[2:0] <= 3'h4)
                     mode_next = asf_mode_t'(wdata_reg[2:0]);
               end
            end
            default: bresp_next = `ASF_RESP_SLVERR;
         endcase
      end
      if (!extended_set_enable_s2_reg && mode_next == ASF_AM_INDEXED) mode_next = ASF_AM_DIRECT;
      if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = `ASF_RESP_OKAY;
         case (s_axi_araddr)
            `ASF_FLAGS_ADDR: rdata_next = {24'h000000, status_view};
            `ASF_OPA_ADDR: rdata_next = {24'h000000, opa_reg};
            `ASF_OPB_ADDR: rdata_next = {24'h000000, opb_reg};
            `ASF_OP_ADDR: rdata_next = {24'h000000, dest_flags_reg, bitsel_reg, 4'h0};
            `ASF_RESULT_ADDR: rdata_next = {24'h000000, result_reg};
            `ASF_CFG_ADDR: rdata_next = {28'h0000000, extended_set_enable_s2_reg, mode_reg};
            default: begin
               rdata_next = 32'h00000000;
               rresp_next = `ASF_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   // flags and operands are not reset: the core leaves them unknown
   always_ff @(posedge clk) begin
      flags_reg <= flags_next;
      opa_reg <= opa_next;
      opb_reg <= opb_next;
      result_reg <= result_next;
      extended_set_enable_s1_reg <= extended_set_enable;
      extended_set_enable_s2_reg <= extended_set_enable_s1_reg;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         awaddr_reg <= 32'h00000000;
         aw_have_reg <= 1'b0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         w_have_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
         rvalid_reg <= 1'b0;
         rresp_reg <= 2'h0;
         rdata_reg <= 32'h00000000;
         bitsel_reg <= 3'h0;
         dest_flags_reg <= 1'b0;
         mode_reg <= ASF_AM_INHERENT;
      end else begin
         awaddr_reg <= awaddr_next;
         aw_have_reg <= aw_have_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         w_have_reg <= w_have_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         bitsel_reg <= bitsel_next;
         dest_flags_reg <= dest_flags_next;
         mode_reg <= mode_next;
      end
   end

   logic [7:0] a_q;
   logic [7:0] b_q;
   logic [3:0] op_q;
   logic op_q_valid;
   logic dst_q;
   always_ff @(posedge clk) begin
      a_q <= src;
      b_q <= opb_reg;
      op_q <= wdata_reg[3:0];
      dst_q <= wdata_reg[7];
      op_q_valid <= resetn && op_go;
   end

   // flags carry no reset; the hold check waits until software has loaded them
   logic hold_armed_reg;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         hold_armed_reg <= 1'b0;
      end else if (wr_fire && awaddr_reg == `ASF_FLAGS_ADDR && wstrb_reg[0]) begin
         hold_armed_reg <= 1'b1;
      end
   end

   add_carry_a: assert property (@(posedge clk) disable iff (!resetn)
      op_q_valid && op_q == 4'h0 && !dst_q |-> flags_reg[0] == ({1'b0, a_q} + {1'b0, b_q}) >> 8)
      else $error("carry wrong after add");
   sub_borrow_a: assert property (@(posedge clk) disable iff (!resetn)
      op_q_valid && op_q == 4'h1 && !dst_q |-> flags_reg[0] == (a_q >= b_q))
      else $error("inverted borrow wrong after subtract");
   sub_digit_a: assert property (@(posedge clk) disable iff (!resetn)
      op_q_valid && op_q == 4'h1 && !dst_q |-> flags_reg[1] == (a_q[3:0] >= b_q[3:0]))
      else $error("digit borrow wrong after subtract");
   zero_flag_a: assert property (@(posedge clk) disable iff (!resetn)
      op_q_valid && op_q <= 4'h2 && !dst_q |-> flags_reg[2] == (result_reg == 8'h00))
      else $error("zero flag disagrees with result");
   neg_flag_a: assert property (@(posedge clk) disable iff (!resetn)
      op_q_valid && op_q <= 4'h2 && !dst_q |-> flags_reg[4] == result_reg[7])
      else $error("negative flag disagrees with result");
   clr_status_a: assert property (@(posedge clk) disable iff (!resetn)
      op_q_valid && op_q == 4'h3 && dst_q |-> flags_reg[2] && flags_reg[4:3] == $past(flags_reg[4:3]))
      else $error("clear of status register wrong");
   upper_zero_a: assert property (@(posedge clk) alu_condition_flags[7:5] == 3'h0)
      else $error("unimplemented bits not zero");
   rot_carry_a: assert property (@(posedge clk) disable iff (!resetn)
      op_q_valid && op_q == 4'h4 && !dst_q |-> flags_reg[0] == a_q[7] && result_reg[0] == $past(flags_reg[0]))
      else $error("rotate left carry wrong");
   flags_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      hold_armed_reg && !op_go && !(wr_fire && awaddr_reg == `ASF_FLAGS_ADDR) |=> $stable(flags_reg))
      else $error("flags moved without an instruction");
   add_seen_c: cover property (@(posedge clk) op_q_valid && op_q == 4'h0);
   sub_borrow_c: cover property (@(posedge clk) op_q_valid && op_q == 4'h1 && !flags_reg[0]);
   clr_status_c: cover property (@(posedge clk) op_q_valid && op_q == 4'h3 && dst_q);
endmodule : asf_alu_status_flags

// ---- asf_alu_status_flags_bench.sv ----
// self-checking bench for the status flag block
// assumes the AXI4-Lite slave map and the flag port of asf_alu_status_flags
`timescale 1ns/1ns
`include "asf_regs.svh"
module asf_alu_status_flags_bench
   import asf_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [31:0] aw_a = 32'h0;
   logic [31:0] w_d = 32'h0;
   logic [31:0] ar_a = 32'h0;
   logic aw_v = 1'b0;
   logic w_v = 1'b0;
   logic b_rdy = 1'b0;
   logic ar_v = 1'b0;
   logic r_rdy = 1'b0;
   logic ext = 1'b0;
   logic [3:0] w_s = 4'hF;
   logic aw_r, w_r, b_v, ar_r, r_v;
   logic [1:0] b_rs, r_rs;
   logic [31:0] r_d;
   logic [7:0] flags;
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [7:0] av [6] = '{8'h7F, 8'hFF, 8'h80, 8'h05, 8'h10, 8'h80};
   logic [7:0] bv [6] = '{8'h01, 8'h01, 8'h80, 8'h06, 8'h01, 8'h01};

   always #4 clk = ~clk;

   asf_alu_status_flags i_dut (.clk(clk), .resetn(resetn),
      .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
      .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
      .s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_rdy),
      .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
      .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_rdy),
      .extended_set_enable(ext), .alu_condition_flags(flags));

   task end_sim;
      begin
         $display("checks %0d mismatches %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
         end else begin
            $display("Test failed");
         end
         $finish;
      end
   endtask : end_sim

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails = fails + 1;
         end_sim();
      end
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      begin
         tests_run++;
         if (g !== e) begin
            fails++;
            $display("wrong value %s exp %h got %h", n, e, g);
         end
      end
   endtask : chk

   // ready is judged at the falling edge, where the combinational ready has
   // settled and cannot change before the rising edge that takes the item
   task wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
      logic ta, tw, da, dw, got;
      begin
         da = 1'b0;
         dw = 1'b0;
         got = 1'b0;
         aw_a <= a;
         w_d <= d;
         aw_v <= 1'b1;
         w_v <= 1'b1;
         b_rdy <= 1'b1;
         while (!(da && dw)) begin
            @(negedge clk);
            ta = aw_v && aw_r;
            tw = w_v && w_r;
            @(posedge clk);
            if (ta) aw_v <= 1'b0;
            if (tw) w_v <= 1'b0;
            da = da | ta;
            dw = dw | tw;
         end
         while (!got) begin
            @(negedge clk);
            got = b_v;
            rs = b_rs;
            @(posedge clk);
         end
      end
   endtask : wr

   task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
      logic t, got;
      begin
         t = 1'b0;
         got = 1'b0;
         ar_a <= a;
         ar_v <= 1'b1;
         r_rdy <= 1'b1;
         while (!t) begin
            @(negedge clk);
            t = ar_r;
            @(posedge clk);
         end
         ar_v <= 1'b0;
         while (!got) begin
            @(negedge clk);
            got = r_v;
            d = r_d;
            rs = r_rs;
            @(posedge clk);
         end
      end
   endtask : rd

   task wreg(input logic [31:0] a, input logic [31:0] d);
      logic [1:0] rs;
      begin
         wr(a, d, rs);
         chk("bresp", {30'h0, `ASF_RESP_OKAY}, {30'h0, rs});
      end
   endtask : wreg

   task rchk(input string n, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] rs;
      begin
         rd(a, d, rs);
         chk(n, e, d);
      end
   endtask : rchk

   task fchk(input logic [7:0] e);
      begin
         rchk("flags_reg", `ASF_FLAGS_ADDR, {24'h0, e});
         chk("flags_port", {24'h0, e}, {24'h0, flags});
      end
   endtask : fchk

   function automatic logic [31:0] opw(input logic d, input logic [2:0] s, input asf_op_t o);
      return {24'h0, d, s, o};
   endfunction : opw

   task op(input logic [7:0] a, input logic [7:0] b, input logic [31:0] o);
      begin
         wreg(`ASF_OPA_ADDR, {24'h0, a});
         wreg(`ASF_OPB_ADDR, {24'h0, b});
         wreg(`ASF_OP_ADDR, o);
      end
   endtask : op

   // subtract reckoned as a + ~b + 1, so carries come out as inverted borrows
   function automatic logic [7:0] fexp(input logic [7:0] a, input logic [7:0] b, input logic s);
      logic [7:0] bb;
      logic [8:0] r;
      logic [4:0] h;
      begin
         bb = s ? ~b : b;
         r = {1'b0, a} + {1'b0, bb} + {8'h0, s};
         h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, s};
         return {3'h0, r[7], (a[7] == bb[7]) && (r[7] != a[7]), r[7:0] == 8'h00, h[4], r[8]};
      end
   endfunction : fexp

   task t_reserved;
      begin
         wreg(`ASF_FLAGS_ADDR, 32'hFFFFFFFF);
         fchk(8'h1F);
         wreg(`ASF_FLAGS_ADDR, 32'h0000000A);
         fchk(8'h0A);
         w_s <= 4'hE;
         wreg(`ASF_FLAGS_ADDR, 32'h00000015);
         fchk(8'h0A);
         w_s <= 4'hF;
      end
   endtask : t_reserved

   task t_arith;
      begin
         for (int i = 0; i < 6; i++) begin
            op(av[i], bv[i], opw(1'b0, 3'h0, i < 3 ? ASF_OP_ADD : ASF_OP_SUB));
            fchk(fexp(av[i], bv[i], i >= 3));
            rchk("result", `ASF_RESULT_ADDR, {24'h0, i < 3 ? av[i] + bv[i] : av[i] - bv[i]});
         end
      end
   endtask : t_arith

   task t_rotate;
      begin
         wreg(`ASF_FLAGS_ADDR, 32'h00000001);
         op(8'h88, 8'h00, opw(1'b0, 3'h0, ASF_OP_ROTL));
         fchk(8'h03);
         rchk("rotl", `ASF_RESULT_ADDR, 32'h00000011);
         wreg(`ASF_FLAGS_ADDR, 32'h00000008);
         op(8'h11, 8'h00, opw(1'b0, 3'h0, ASF_OP_ROTR));
         fchk(8'h0B);
         rchk("rotr", `ASF_RESULT_ADDR, 32'h00000008);
      end
   endtask : t_rotate

   task t_status_dst;
      begin
         wreg(`ASF_FLAGS_ADDR, 32'h0000001B);
         op(8'h00, 8'h00, opw(1'b1, 3'h0, ASF_OP_CLR));
         fchk(8'h1F);
         wreg(`ASF_FLAGS_ADDR, 32'h0000000F);
         op(8'h00, 8'hF1, opw(1'b1, 3'h0, ASF_OP_ADD));
         fchk(8'h07);
         wreg(`ASF_FLAGS_ADDR, 32'h0000000B);
         op(8'h00, 8'hF0, opw(1'b1, 3'h0, ASF_OP_AND));
         fchk(8'h0F);
         wreg(`ASF_FLAGS_ADDR, 32'h00000003);
         op(8'h00, 8'h00, opw(1'b1, 3'h4, ASF_OP_BITSET));
         fchk(8'h13);
         op(8'h00, 8'h00, opw(1'b1, 3'h0, ASF_OP_BITCLR));
         fchk(8'h12);
         op(8'h00, 8'h00, opw(1'b1, 3'h0, ASF_OP_SWAP));
         fchk(8'h01);
      end
   endtask : t_status_dst

   task t_hold;
      begin
         wreg(`ASF_FLAGS_ADDR, 32'h0000000B);
         op(8'h80, 8'hF0, opw(1'b0, 3'h0, ASF_OP_AND));
         fchk(8'h1B);
         rchk("and", `ASF_RESULT_ADDR, 32'h00000080);
         op(8'h00, 8'h00, opw(1'b0, 3'h0, ASF_OP_MOVE));
         fchk(8'h1B);
      end
   endtask : t_hold

   task t_unmapped;
      logic [31:0] d;
      logic [1:0] rs;
      begin
         wr(32'h00000100, 32'h00000055, rs);
         chk("bresp_unmapped", {30'h0, `ASF_RESP_SLVERR}, {30'h0, rs});
         rd(32'h00000100, d, rs);
         chk("rresp_unmapped", {30'h0, `ASF_RESP_SLVERR}, {30'h0, rs});
         chk("rdata_unmapped", 32'h00000000, d);
      end
   endtask : t_unmapped

   // the enable crosses a two-flop synchroniser, hence the three idle cycles
   task t_modes;
      begin
         for (int m = 0; m < 4; m++) begin
            wreg(`ASF_CFG_ADDR, m);
            rchk("mode", `ASF_CFG_ADDR, m);
         end
         wreg(`ASF_CFG_ADDR, 32'h00000004);
         rchk("mode_idx_off", `ASF_CFG_ADDR, 32'h00000002);
         ext <= 1'b1;
         repeat (3) @(posedge clk);
         wreg(`ASF_CFG_ADDR, 32'h00000004);
         rchk("mode_idx_on", `ASF_CFG_ADDR, 32'h0000000C);
         ext <= 1'b0;
         repeat (3) @(posedge clk);
         rchk("mode_idx_drop", `ASF_CFG_ADDR, 32'h00000002);
      end
   endtask : t_modes

   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      t_reserved();
      t_arith();
      t_rotate();
      t_status_dst();
      t_hold();
      t_unmapped();
      t_modes();
      end_sim();
   end
endmodule : asf_alu_status_flags_bench

// ---- asf_pkg.sv ----
// types for the status flag block
// assumes asf_regs.svh is included by the design
package asf_pkg;
   typedef enum logic [3:0] {
      ASF_OP_ADD = 4'h0,
      ASF_OP_SUB = 4'h1,
      ASF_OP_AND = 4'h2,
      ASF_OP_CLR = 4'h3,
      ASF_OP_ROTL = 4'h4,
      ASF_OP_ROTR = 4'h5,
      ASF_OP_MOVE = 4'h6,
      ASF_OP_BITCLR = 4'h7,
      ASF_OP_BITSET = 4'h8,
      ASF_OP_SWAP = 4'h9
   } asf_op_t;
   typedef enum logic [2:0] {
      ASF_AM_INHERENT = 3'h0,
      ASF_AM_LITERAL = 3'h1,
      ASF_AM_DIRECT = 3'h2,
      ASF_AM_INDIRECT = 3'h3,
      ASF_AM_INDEXED = 3'h4
   } asf_mode_t;
endpackage : asf_pkg

// ---- asf_regs.svh ----
// constants of the status flag block; no assumptions beyond an includer
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH
`define ASF_FLAGS_INDEX 12'hFDB
`define ASF_FLAGS_ADDR 32'h00003F6C
`define ASF_OP_ADDR 32'h00000000
`define ASF_OPA_ADDR 32'h00000004
`define ASF_OPB_ADDR 32'h00000008
`define ASF_RESULT_ADDR 32'h0000000C
`define ASF_CFG_ADDR 32'h00000010
`define ASF_BIT_NEG 4
`define ASF_BIT_OVF 3
`define ASF_BIT_ZERO 2
`define ASF_BIT_HALF 1
`define ASF_BIT_CARRY 0
`define ASF_FLAG_MASK 8'h1F
`define ASF_RESP_OKAY 2'h0
`define ASF_RESP_SLVERR 2'h2
`endif
